// [jnr_pkg.sv]
/*
 * Shared constants for the programming data registers behind the test access port:
 * instruction codes, register widths, the enable signature, command prefixes and counts.
 * Assumes a separate test access port controller supplies the instruction and state flags.
 */
// Overview of operation
// RULE1: Command-entry instruction 0x5 puts the 15-bit command register between TDI and TDO.
// RULE2: Capture-DR under command entry loads the previous command's result into the register.
// RULE3: Shift-DR under command entry moves one place per TCK; result out, command in.
// RULE4: Update-DR under command entry drives the shifted command onto memory control inputs.
// RULE5: Run-Test/Idle after a command update gives one execute pulse.
// RULE6: Page-load 0x6 selects the low eight command bits as a data byte, shifted by TCK.
// RULE7: Page-load Update-DR copies the byte to a holding register, written within 11 TCK.
// RULE8: Page-load updates alternate low then high byte, low byte first after entry.
// RULE9: Page-load pre-increments the word address before each low byte except the first.
// RULE10: Page-read 0x7 captures flash bytes on Capture-DR, low byte then high byte.
// RULE11: Page-read increments the word address after every high byte capture.
// RULE12: A one in the reset register holds the core in reset immediately.
// RULE13: After the reset bit clears, reset stays for the reset time-out period.
// RULE14: The programmer resets the device before entering programming mode.
// RULE15: Programming is enabled only while the 16-bit enable register equals the signature.
// RULE16: The enable register clears on power-on reset; programmer clears it when leaving.
// RULE17: Chip erase is a fixed command sequence followed by polling for completion.
// RULE18: Flash write enters write mode, loads address high, low, and data bytes.
// RULE19: Flash words are latched, the page committed, then status polled on TDO.
// RULE20: Flash read returns low byte, then high byte, after the read commands.
// RULE21: EEPROM write loads address and byte, latches, commits and polls.
// RULE22: EEPROM read starts with enter-read then address high byte load.
// RULE23: Every data register shifts least significant bit first on TDI and TDO.
// RULE24: The programmer may skip an address-high load when already correct.
// RULE25: Without the signature, programming commands are ignored and memory left untouched.
// RULE26: Data byte shifting or updating touches only the low eight command bits.
package jnr_pkg;
    // ----------------------------------------------------------------
    // Instruction codes and widths
    // ----------------------------------------------------------------
    localparam int          IR_W        = 4;
    localparam logic [3:0]  INSTR_RESET = 4'hC;
    localparam logic [3:0]  INSTR_PE    = 4'h4;
    localparam logic [3:0]  INSTR_CMD   = 4'h5;
    localparam logic [3:0]  INSTR_PLOAD = 4'h6;
    localparam logic [3:0]  INSTR_PREAD = 4'h7;
    localparam int          CMD_W       = 15;
    localparam int          BYTE_W      = 8;
    localparam int          PE_W        = 16;
    localparam int          PC_W        = 16;
    localparam int          PFX_W       = 7;
    // ----------------------------------------------------------------
    // Values, prefixes and counts
    // ----------------------------------------------------------------
    localparam logic [15:0] PE_SIG      = 16'hA370;
    localparam logic [15:0] PE_RST      = 16'h0000;
    localparam logic [6:0]  PFX_ADDR_HI = 7'h07;
    localparam logic [6:0]  PFX_ADDR_LO = 7'h03;
    localparam int          RST_TOUT_CYC = 64;
    localparam int          PB_DEPTH    = 16;
    localparam int          PB_W        = PC_W + 1 + BYTE_W;
endpackage

// [jnr_sync.sv]
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to i_clk; each bit is treated on its own.
 */
`timescale 1ns/1ps
module jnr_sync #(
    parameter int W = 2
) (
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // ----------------------------------------------------------------
    // Per-bit synchroniser stages
    // ----------------------------------------------------------------
    // Each bit passes two flops; only the second is read outside.
    for (genvar b = 0; b < W; b++)
    begin : g_bit
        always_ff @(posedge i_clk or negedge i_arst_n)
        begin
            if (!i_arst_n)
            begin
                meta_ff[b] <= 1'b0;
                sync_ff[b] <= 1'b0;
            end
            else
            begin
                meta_ff[b] <= i_async[b];
                sync_ff[b] <= meta_ff[b];
            end
        end
    end

    assign o_sync = sync_ff;
endmodule

// [jnr_fifo.sv]
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; depth is a power of two.
 */
`timescale 1ns/1ps
module jnr_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic      [W-1:0] o_out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr_ff;
    logic [AW:0]  rd_ptr_ff;
    logic         full;
    logic         empty;
    logic         push;
    logic         pop;

    // ----------------------------------------------------------------
    // Status and handshakes
    // ----------------------------------------------------------------
    // Pointers carry an extra wrap bit so full and empty are exact.
    assign empty       = (wr_ptr_ff == rd_ptr_ff);
    assign full        = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign push        = i_in_valid && !full;
    assign pop         = i_out_ready && !empty;
    assign o_in_ready  = !full;
    assign o_out_valid = !empty;
    assign o_out_data  = mem[rd_ptr_ff[AW-1:0]];

    // Storage is read only after it has been written, so it needs no reset.
    always_ff @(posedge i_clk)
    begin
        if (push)
            mem[wr_ptr_ff[AW-1:0]] <= i_in_data;
    end

    // Pointer update.
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (pop)
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end
endmodule

// [jnr_prog_regs.sv]
/*
 * Programming data registers behind the test access port: reset bit, enable register,
 * shared command / data byte register, page-load and page-read sequencing, command execution.
 * Assumes an outside controller supplies the instruction and Capture/Shift/Update/Idle flags
 * on i_clk, held stable for a whole TCK period and changed only while TCK is low.
 */
`timescale 1ns/1ps
module jnr_prog_regs
    import jnr_pkg::*;
#(
    parameter int TOUT_CYC = jnr_pkg::RST_TOUT_CYC,
    parameter int FIFO_D   = jnr_pkg::PB_DEPTH
) (
    input  wire logic                         i_clk,
    input  wire logic                         i_arst_n,
    input  wire logic                         i_tck,
    input  wire logic                         i_tdi,
    input  wire logic [jnr_pkg::IR_W-1:0]     i_instr,
    input  wire logic                         i_capture_dr,
    input  wire logic                         i_shift_dr,
    input  wire logic                         i_update_dr,
    input  wire logic                         i_run_idle,
    input  wire logic [jnr_pkg::CMD_W-1:0]    i_nvm_result,
    input  wire logic [2*jnr_pkg::BYTE_W-1:0] i_flash_rdata,
    input  wire logic                         i_pb_ready,
    output logic                              o_tdo,
    output logic                              o_tdo_oe,
    output logic                              o_core_reset,
    output logic                              o_prog_en,
    output logic      [jnr_pkg::CMD_W-1:0]    o_nvm_cmd,
    output logic                              o_nvm_cmd_stb,
    output logic                              o_nvm_exec,
    output logic      [jnr_pkg::PC_W-1:0]     o_pc,
    output logic                              o_pb_valid,
    output logic      [jnr_pkg::PC_W-1:0]     o_pb_addr,
    output logic                              o_pb_hi,
    output logic      [jnr_pkg::BYTE_W-1:0]   o_pb_data
);
    import jnr_pkg::*;

    localparam int TW = $clog2(TOUT_CYC + 1);

    // ----------------------------------------------------------------
    // Pin synchronisation and TCK edges
    // ----------------------------------------------------------------
    logic [1:0]        pins_s;
    logic              tck_s;
    logic              tdi_s;
    logic              tck_q_ff;
    logic              tck_rise;
    logic              tck_fall;

    jnr_sync #(.W(2)) u_sync (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_async  ({i_tck, i_tdi}),
        .o_sync   (pins_s)
    );

    // Edge detection works on the second synchroniser stage only.
    assign tck_s    = pins_s[1];
    assign tdi_s    = pins_s[0];
    assign tck_rise = tck_s && !tck_q_ff;
    assign tck_fall = !tck_s && tck_q_ff;

    // ----------------------------------------------------------------
    // Decode of instruction and active state
    // ----------------------------------------------------------------
    logic              sel_cmd, sel_pload, sel_pread, sel_pe, sel_rst, sel_byte;
    logic              do_cap, do_shift, do_upd;
    logic [IR_W-1:0]   instr_q_ff;
    logic              instr_new;

    assign sel_cmd   = (i_instr == INSTR_CMD);
    assign sel_pload = (i_instr == INSTR_PLOAD);
    assign sel_pread = (i_instr == INSTR_PREAD);
    assign sel_pe    = (i_instr == INSTR_PE);
    assign sel_rst   = (i_instr == INSTR_RESET);
    assign sel_byte  = sel_pload || sel_pread;
    assign do_cap    = tck_rise && i_capture_dr;
    assign do_shift  = tck_rise && i_shift_dr;
    assign do_upd    = tck_rise && i_update_dr;
    assign instr_new = (i_instr != instr_q_ff);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [CMD_W-1:0]  dr_ff;
    logic [PE_W-1:0]   pe_ff;
    logic              rst_bit_ff;
    logic [TW-1:0]     tout_ff;
    logic [PC_W-1:0]   pc_ff;
    logic              ld_hi_ff, ld_first_ff, rd_hi_ff, cmd_pend_ff;
    logic              wr_pend_ff;
    logic [PB_W-1:0]   wr_word_ff;
    logic [BYTE_W-1:0] hold_ff;
    logic [PC_W-1:0]   ld_addr;
    logic [BYTE_W-1:0] rd_byte;
    logic              ld_go, rd_go, cmd_go;
    logic [PC_W-1:0]   nxt_pc;

    // Programming actions happen only while the signature is held.
    assign cmd_go  = do_upd && sel_cmd && o_prog_en;              // [RULE25]
    assign ld_go   = do_upd && sel_pload && o_prog_en;            // [RULE25]
    assign rd_go   = do_cap && sel_pread && o_prog_en;            // [RULE25]
    // Low bytes after the first go one word further on.
    assign ld_addr = (!ld_hi_ff && !ld_first_ff) ? pc_ff + 1'b1 : pc_ff;  // [RULE9]
    assign rd_byte = rd_hi_ff ? i_flash_rdata[2*BYTE_W-1:BYTE_W] : i_flash_rdata[BYTE_W-1:0];  // [RULE10]

    // Next word address from address loads, page-load and page-read.
    assign nxt_pc = (cmd_go && dr_ff[CMD_W-1 -: PFX_W] == PFX_ADDR_HI) ? {dr_ff[BYTE_W-1:0], pc_ff[BYTE_W-1:0]} :
                    (cmd_go && dr_ff[CMD_W-1 -: PFX_W] == PFX_ADDR_LO) ? {pc_ff[PC_W-1:BYTE_W], dr_ff[BYTE_W-1:0]} :
                    ld_go ? ld_addr :                                                          // [RULE9]
                    (rd_go && rd_hi_ff) ? pc_ff + 1'b1 : pc_ff;                                // [RULE11]

    // Shared command / data byte register; byte instructions touch the low eight bits only.
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            dr_ff <= '0;
        else if (do_cap && sel_cmd)
            dr_ff <= i_nvm_result;                                          // [RULE2] [RULE20]
        else if (do_shift && sel_cmd)
            dr_ff <= {tdi_s, dr_ff[CMD_W-1:1]};                             // [RULE1] [RULE3] [RULE23]
        else if (do_shift && sel_byte)
            dr_ff[BYTE_W-1:0] <= {tdi_s, dr_ff[BYTE_W-1:1]};                // [RULE6] [RULE26]
        else if (rd_go)
            dr_ff[BYTE_W-1:0] <= rd_byte;                                   // [RULE10] [RULE26]
    end

    // Reset bit and enable register shift LSB first; enable clears on power-on.
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_bit_ff <= 1'b0;
            pe_ff      <= PE_RST;                                           // [RULE16]
        end
        else if (do_shift && sel_rst)
            rst_bit_ff <= tdi_s;
        else if (do_shift && sel_pe)
            pe_ff      <= {tdi_s, pe_ff[PE_W-1:1]};                         // [RULE23]
    end

    // Reset output follows the bit at once and stretches by the time-out after release.
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            tout_ff      <= '0;
            o_core_reset <= 1'b0;
        end
        else
        begin
            if (rst_bit_ff)
                tout_ff <= TW'(TOUT_CYC);                                   // [RULE13]
            else if (tout_ff != '0)
                tout_ff <= tout_ff - 1'b1;
            o_core_reset <= rst_bit_ff || (tout_ff != '0);                  // [RULE12] [RULE13]
        end
    end

    // Sequencing state: address, byte phases, pending execute and the enable output.
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            tck_q_ff    <= 1'b0;
            instr_q_ff  <= '0;
            pc_ff       <= '0;
            ld_hi_ff    <= 1'b0;
            ld_first_ff <= 1'b1;
            rd_hi_ff    <= 1'b0;
            cmd_pend_ff <= 1'b0;
            o_prog_en   <= 1'b0;
        end
        else
        begin
            tck_q_ff   <= tck_s;
            instr_q_ff <= i_instr;
            pc_ff      <= nxt_pc;
            o_prog_en  <= (pe_ff == PE_SIG);                                // [RULE15]
            if (instr_new)
            begin
                ld_hi_ff    <= 1'b0;                                        // [RULE8]
                ld_first_ff <= 1'b1;
                rd_hi_ff    <= 1'b0;                                        // [RULE10]
            end
            else
            begin
                if (ld_go)
                begin
                    ld_hi_ff    <= !ld_hi_ff;                               // [RULE8]
                    ld_first_ff <= 1'b0;
                end
                if (rd_go)
                    rd_hi_ff <= !rd_hi_ff;                                  // [RULE10]
            end
            if (cmd_go)
                cmd_pend_ff <= 1'b1;
            else if (tck_rise && i_run_idle)
                cmd_pend_ff <= 1'b0;
        end
    end

    // Command drive and execute pulse.
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_nvm_cmd     <= '0;
            o_nvm_cmd_stb <= 1'b0;
            o_nvm_exec    <= 1'b0;
        end
        else
        begin
            if (cmd_go)
                o_nvm_cmd <= dr_ff;                                         // [RULE4]
            o_nvm_cmd_stb <= cmd_go;
            o_nvm_exec    <= cmd_pend_ff && tck_rise && i_run_idle && o_prog_en;  // [RULE5]
        end
    end

    // ----------------------------------------------------------------
    // Page buffer write path
    // ----------------------------------------------------------------
    logic            fifo_in_ready;
    logic            fifo_out_valid;
    logic            fifo_take;
    logic [PB_W-1:0] fifo_out_data;

    // A byte waits in the holding word until the FIFO accepts it.
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            hold_ff    <= '0;
            wr_pend_ff <= 1'b0;
            wr_word_ff <= '0;
        end
        else if (ld_go)
        begin
            hold_ff    <= dr_ff[BYTE_W-1:0];                                // [RULE7]
            wr_pend_ff <= 1'b1;
            wr_word_ff <= {ld_addr, ld_hi_ff, dr_ff[BYTE_W-1:0]};           // [RULE8]
        end
        else if (fifo_in_ready)
            wr_pend_ff <= 1'b0;
    end

    jnr_fifo #(.W(PB_W), .D(FIFO_D)) u_fifo (
        .i_clk       (i_clk),
        .i_arst_n    (i_arst_n),
        .i_in_valid  (wr_pend_ff),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (wr_word_ff),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_take),
        .o_out_data  (fifo_out_data)
    );

    // Output stage reloads whenever it is empty or the page buffer took its word.
    assign fifo_take = !o_pb_valid || i_pb_ready;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_pb_valid <= 1'b0;
            o_pb_addr  <= '0;
            o_pb_hi    <= 1'b0;
            o_pb_data  <= '0;
        end
        else if (fifo_take)
        begin
            o_pb_valid <= fifo_out_valid;                                   // [RULE7]
            if (fifo_out_valid)
                {o_pb_addr, o_pb_hi, o_pb_data} <= fifo_out_data;
        end
    end

    assign o_pc = pc_ff;

    // ----------------------------------------------------------------
    // TDO drive on the falling TCK edge
    // ----------------------------------------------------------------
    logic tdo_bit;

    assign tdo_bit = (sel_cmd || sel_byte) ? dr_ff[0] : sel_pe ? pe_ff[0] : sel_rst ? rst_bit_ff : 1'b0;

    // Output changes on the falling edge so the programmer samples it on the next rise.
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_tdo    <= 1'b0;
            o_tdo_oe <= 1'b0;
        end
        else if (tck_fall)
        begin
            o_tdo    <= tdo_bit;                                            // [RULE23]
            o_tdo_oe <= i_shift_dr;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    property p_cmd_capture;
        do_cap && sel_cmd |=> dr_ff == $past(i_nvm_result);
    endproperty
    a_cmd_capture: assert property (p_cmd_capture) else $error("Capture missed the result."); // [RULE2]

    property p_cmd_shift;
        do_shift && sel_cmd |=> dr_ff == {$past(tdi_s), $past(dr_ff[CMD_W-1:1])};
    endproperty
    a_cmd_shift: assert property (p_cmd_shift) else $error("Command shift wrong."); // [RULE3]

    property p_byte_upper_kept;
        tck_rise && sel_byte && !instr_new |=> $stable(dr_ff[CMD_W-1:BYTE_W]);
    endproperty
    a_byte_upper_kept: assert property (p_byte_upper_kept) else $error("Upper command bits changed."); // [RULE26]

    property p_cmd_apply;
        cmd_go |=> o_nvm_cmd == $past(dr_ff) && o_nvm_cmd_stb;
    endproperty
    a_cmd_apply: assert property (p_cmd_apply) else $error("Command not applied."); // [RULE4]

    property p_exec_gated;
        o_nvm_exec |-> o_prog_en && $past(cmd_pend_ff) && $past(i_run_idle);
    endproperty
    a_exec_gated: assert property (p_exec_gated) else $error("Execute without cause."); // [RULE5]

    property p_no_write_locked;
        tck_rise && i_update_dr && sel_pload && !o_prog_en |=> !wr_pend_ff || $stable(wr_word_ff);
    endproperty
    a_no_write_locked: assert property (p_no_write_locked) else $error("Write while locked."); // [RULE25]

    property p_first_low;
        ld_go && ld_first_ff |=> pc_ff == $past(pc_ff) && !wr_word_ff[BYTE_W] && ld_hi_ff;
    endproperty
    a_first_low: assert property (p_first_low) else $error("First load byte misplaced."); // [RULE9]

    property p_read_inc;
        rd_go && rd_hi_ff |=> pc_ff == $past(pc_ff) + 1'b1;
    endproperty
    a_read_inc: assert property (p_read_inc) else $error("Read address not advanced."); // [RULE11]

    property p_reset_now;
        rst_bit_ff |=> o_core_reset;
    endproperty
    a_reset_now: assert property (p_reset_now) else $error("Reset bit not obeyed."); // [RULE12]

    property p_reset_hold;
        $fell(rst_bit_ff) |=> o_core_reset [*8];
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("Reset time-out cut short."); // [RULE13]

    property p_enable_sig;
        o_prog_en |-> $past(pe_ff) == PE_SIG;
    endproperty
    a_enable_sig: assert property (p_enable_sig) else $error("Enabled without signature."); // [RULE15]

    property p_hold_copy;
        ld_go |=> hold_ff == $past(dr_ff[BYTE_W-1:0]) && wr_pend_ff;
    endproperty
    a_hold_copy: assert property (p_hold_copy) else $error("Holding register not loaded."); // [RULE7]

    c_exec: cover property (o_nvm_exec);
    c_pb_write: cover property (o_pb_valid && i_pb_ready && o_pb_hi);
    c_read_hi: cover property (rd_go && rd_hi_ff);
    c_reset_release: cover property ($fell(o_core_reset));
endmodule

// [jnr_host.sv]
/* Programmer model: drives TCK, TDI, TAP flags and instruction at i_clk falls. */
`timescale 1ns/1ps
module jnr_host (
    input  wire logic       i_clk,
    input  wire logic       i_tdo,
    output logic            o_tck,
    output logic            o_tdi,
    output logic [3:0]      o_ir,
    output logic [3:0]      o_st
);
    initial {o_tck, o_tdi, o_ir, o_st} = '0;  // TCK stands low between frames.
    // Capture, n shifts, update, idle; each TCK is 320 ns, TDO taken before the fall.
    task automatic scan(input logic [3:0] ir, input int n, input logic [15:0] w, output logic [15:0] r);
        o_ir = ir;
        for (int k = -1; k <= n + 1; k++)
        begin
            @(negedge i_clk);
            o_st = k < 0 ? 4'h8 : k < n ? 4'h4 : k == n ? 4'h2 : 4'h1;
            o_tdi = w[k[3:0]];
            repeat (3) @(negedge i_clk);
            o_tck = 1'b1;
            repeat (4) @(negedge i_clk);
            if (k >= 0 && k < n) r[k] = i_tdo;
            o_tck = 1'b0;
        end
    endtask
endmodule

// [testbench.sv]
/* Self-checking bench; assumes jnr_host plays the programmer. */
`timescale 1ns/1ps
module testbench;
    import jnr_pkg::*;
    logic        i_clk = 0, i_arst_n = 0, i_pb_ready = 0;
    logic [14:0] i_nvm_result = '0, cmd;
    logic [3:0]  ir, st;
    logic        tck, tdi, tdo, rst, pen, pv, ph, oe, stb, ex;
    logic [15:0] pc, pa, r, a, fl, ec[24];
    logic [7:0]  pd, b[4];
    logic [24:0] got[$];
    int          n_errors = 0, total_checks = 0;
    int          n_exec = 0, n_stb = 0, n_oe = 0;
    assign fl = pc ^ 16'hC35A;  // Flash word is its address scrambled.
    jnr_prog_regs #(.TOUT_CYC(40)) DUT (.i_clk, .i_arst_n, .i_tck(tck), .i_tdi(tdi), .i_instr(ir),
        .i_capture_dr(st[3]), .i_shift_dr(st[2]), .i_update_dr(st[1]), .i_run_idle(st[0]), .i_nvm_result,
        .i_flash_rdata(fl), .i_pb_ready, .o_tdo(tdo), .o_tdo_oe(oe), .o_core_reset(rst), .o_prog_en(pen),
        .o_nvm_cmd(cmd), .o_nvm_cmd_stb(stb), .o_nvm_exec(ex), .o_pc(pc), .o_pb_valid(pv), .o_pb_addr(pa),
        .o_pb_hi(ph), .o_pb_data(pd));
    jnr_host H (.i_clk, .i_tdo(tdo), .o_tck(tck), .o_tdi(tdi), .o_ir(ir), .o_st(st));
    always #20 i_clk = ~i_clk;  // 25 MHz clock.
    // Redraws the buffer stall, logs the handshake that the next rising edge completes, counts pulses.
    always @(negedge i_clk)
    begin
        i_pb_ready = ($urandom % 3) != 0;
        if (pv && i_pb_ready) got.push_back({pa, ph, pd});
        n_exec += ex;
        n_stb += stb;
        n_oe += oe;
    end
    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [24:0] s, input logic [24:0] x);
        total_checks++;
        n_errors += int'(s !== x);
        if (s !== x) $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog far past the 200 us the tests take.
    initial
    begin
        #1_000_000 n_errors++;
        print_verdict;
    end
    // Reset, enable, commands, page read, page load, leave.
    initial
    begin
        void'($urandom(93));
        repeat (16) @(negedge i_clk);
        i_arst_n = 1;
        H.scan(4'hC, 1, 16'h0001, r);
        chk(rst, 1);
        H.scan(4'h5, 15, 16'h07AA, r);
        chk(pc, 0);
        chk(n_stb, 0);
        H.scan(4'h4, 16, PE_SIG, r);
        chk(pen, 1);
        a = 16'($urandom) & 16'hFFF8;
        ec = '{16'h2380, 16'h3180, 16'h3380, 16'h3380, 16'h2311, 16'h3300, 16'h3100, 16'h3300, 16'h2310,
               16'h1355, 16'h17AA, 16'h3700, 16'h7700, 16'h3700, 16'h3500, 16'h3700, 16'h2303,
               {8'h07, a[15:8]}, 16'h0300, 16'h2302, {8'h03, a[7:0]}, 16'h3200, 16'h3600, 16'h3700};
        i_nvm_result = 15'($urandom);
        foreach (ec[i])
        begin
            H.scan(4'h5, 15, ec[i], r);
            chk(cmd, ec[i]);
        end
        chk(r[14:0], i_nvm_result);
        chk(pc, a);
        chk(n_stb, 24);
        chk(n_exec, 24);
        chk(n_oe, 8 * (1 + 15 + 16 + 24 * 15));
        for (int i = 0; i < 4; i++)
        begin
            H.scan(4'h7, 8, 16'h0000, r);
            chk(r[7:0], 8'((a + 16'(i / 2) ^ 16'hC35A) >> i % 2 * 8));
        end
        foreach (b[i]) b[i] = 8'($urandom);
        foreach (b[i]) H.scan(4'h6, 8, {8'h00, b[i]}, r);
        repeat (40) @(negedge i_clk);
        foreach (b[i]) chk(got[i], {a + 16'(2 + i / 2), 1'(i % 2), b[i]});
        H.scan(4'h4, 16, PE_RST, r);
        chk(pen, 0);
        H.scan(4'h6, 8, 16'h00FF, r);
        H.scan(4'hC, 1, 16'h0000, r);
        chk(rst, 1);
        repeat (30) @(negedge i_clk);
        chk(rst, 0);
        chk(got.size(), 4);
        print_verdict;
    end
endmodule
